// ### src/fsc_cmd.sv
// Purpose: Suspend/resume, deep power-down and ID read command handling
// Assumes: Serial clock well below clk/4; mode 0 framing; busy kind from the array
// Notes:   Array engine starts ops and reports progress; this block gates them
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Suspended: other sectors stay readable; programmable in erase suspend only
// - Suspend taken only if not suspended, busy
// - Suspend ignored during whole-chip erase
// - Erase suspend refuses status write and erases
// - Program suspend refuses status write and programs
// - Suspend sets flag now, busy drops quickly
// - Power loss clears suspended state and flag
// - Resume taken only if suspended and idle
// - Resume clears flag, busy within 200ns
// - Resume ignored after power-loss suspension ends
// - Power-down needs select rise after eighth bit
// - Power-down recognises only the release opcode
// - Device always starts in normal operation
// - Release alone wakes after wake time
// - Release plus dummies streams device ID
// - Release/ID ignored while busy
// - Opcode 90h streams maker then device ID
// - Dual ID: two bits per clock, alternating
// - Busy high during self-timed cycle only
module fsc_cmd
  import fsc_pkg::*;
(
  // Clock and reset (rst_n models power-on)
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Serial pins
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       io0_in,
  input  wire logic       io1_in,
  output logic            io0_out,
  output logic            io0_oe,
  output logic            io1_out,
  output logic            io1_oe,
  // Array engine
  input  wire fsc_op_t    array_op,
  input  wire logic       array_done,
  output logic            array_pause,
  output logic            op_allow,
  // Status
  output logic            busy,
  output logic            suspend_status_bit,
  output logic            powered_down
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic cs_s, sck_s, io0_s, io1_s;
  fsc_sync u_cs  (.clk(clk), .rst_n(rst_n), .d(cs_n),   .q(cs_s));
  fsc_sync u_sck (.clk(clk), .rst_n(rst_n), .d(sck),    .q(sck_s));
  fsc_sync u_io0 (.clk(clk), .rst_n(rst_n), .d(io0_in), .q(io0_s));
  fsc_sync u_io1 (.clk(clk), .rst_n(rst_n), .d(io1_in), .q(io1_s));

  logic sck_d, cs_d;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_d <= 1'b0;
      cs_d  <= 1'b1;
    end else begin
      sck_d <= sck_s;
      cs_d  <= cs_s;
    end
  end

  // Edges count only while selected; select resets high, so no false edge follows reset
  wire sck_rise = !cs_s && sck_s && !sck_d;
  wire sck_fall = !cs_s && !sck_s && sck_d;
  wire cs_rise  = cs_s && !cs_d;

  ////////////////////////////////////////////////////////////////////////////
  // Frame shifter: opcode byte, then clock count
  logic [7:0] opcode;
  logic [5:0] clk_cnt;
  logic       op_done;
  wire        in_opcode = clk_cnt < OP_BITS;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opcode  <= 8'h00;
      clk_cnt <= 6'h00;
      op_done <= 1'b0;
    end else if (cs_s) begin
      clk_cnt <= 6'h00;
      op_done <= 1'b0;
    end else if (sck_rise) begin
      if (in_opcode) opcode <= {opcode[6:0], io0_s};
      if (clk_cnt != 6'h3f) clk_cnt <= clk_cnt + 6'h01;
      op_done <= (clk_cnt == OP_BITS - 6'h01);
    end
  end

  // Command exactly 8 clocks long when select rises
  wire exact8 = cs_rise && (clk_cnt == OP_BITS);

  ////////////////////////////////////////////////////////////////////////////
  // Suspend state
  typedef enum logic [1:0] {S_RUN, S_SUSPENDING, S_SUSPENDED, S_RESUMING} fsc_sus_t;
  fsc_sus_t sus_state;
  fsc_op_t  sus_kind;
  logic [15:0] lat_cnt;

  wire susp_ok = exact8 && !powered_down && (opcode == OP_SUSPEND) && busy
               && !suspend_status_bit
               && (array_op == FSC_OP_ERASE || array_op == FSC_OP_PROG);
  wire res_ok  = exact8 && !powered_down && (opcode == OP_RESUME)
               && suspend_status_bit && !busy;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sus_state <= S_RUN;
      sus_kind  <= FSC_OP_NONE;
      lat_cnt   <= 16'h0000;
    end else begin
      unique case (sus_state)
        S_RUN: begin
          if (susp_ok) begin
            sus_state <= S_SUSPENDING;
            sus_kind  <= array_op;
            lat_cnt   <= 16'h0000;
          end
        end
        S_SUSPENDING: begin
          // Engine is given a fixed slot to reach a safe point
          lat_cnt <= lat_cnt + 16'h0001;
          if (lat_cnt == 16'(SUS_LAT_CYC - 1)) sus_state <= S_SUSPENDED;
        end
        S_SUSPENDED: begin
          if (res_ok) begin
            sus_state <= S_RESUMING;
            lat_cnt   <= 16'h0000;
          end
        end
        S_RESUMING: begin
          // Internal busy covers the gap until the engine reports again
          lat_cnt <= lat_cnt + 16'h0001;
          if (lat_cnt == 16'(RESUME_CYC - 2)) begin
            sus_state <= S_RUN;
            sus_kind  <= FSC_OP_NONE;
          end
        end
      endcase
    end
  end

  assign suspend_status_bit = (sus_state == S_SUSPENDING) || (sus_state == S_SUSPENDED);
  // Busy reflects the engine, masked while paused
  assign busy = ((array_op != FSC_OP_NONE) && !array_done
                && (sus_state == S_RUN)) || (sus_state == S_SUSPENDING)
                || (sus_state == S_RESUMING);
  assign array_pause = (sus_state == S_SUSPENDING) || (sus_state == S_SUSPENDED);

  // Opcode gating toward the engine
  wire is_erase = (opcode == OP_SE) || (opcode == OP_BE32) || (opcode == OP_BE64)
                || (opcode == OP_CE_A) || (opcode == OP_CE_B) || (opcode == OP_SEC_ERASE);
  wire is_prog  = (opcode == OP_PP) || (opcode == OP_QPP) || (opcode == OP_SEC_PROG);
  wire refuse_e = (sus_kind == FSC_OP_ERASE) && (is_erase || opcode == OP_WRSR);
  wire refuse_p = (sus_kind == FSC_OP_PROG) && (is_prog || opcode == OP_WRSR);
  // Other-sector reads, and programs under erase suspend, still pass while suspended
  assign op_allow = op_done && !powered_down && !refuse_e && !refuse_p
                  && !(busy && !suspend_status_bit);

  ////////////////////////////////////////////////////////////////////////////
  // Power-down state
  typedef enum logic [1:0] {P_NORMAL, P_ENTERING, P_DOWN, P_WAKING} fsc_pd_t;
  fsc_pd_t pd_state;
  logic [15:0] pd_cnt;
  wire rel_seen = cs_rise && (opcode == OP_RELEASE) && (clk_cnt >= OP_BITS);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_state <= P_NORMAL;
      pd_cnt   <= 16'h0000;
    end else begin
      unique case (pd_state)
        P_NORMAL: begin
          // Entry refused while busy so a running cycle is never cut short
          if (exact8 && opcode == OP_PWRDOWN && !busy) begin
            pd_state <= P_ENTERING;
            pd_cnt   <= 16'h0000;
          end
        end
        P_ENTERING: begin
          pd_cnt <= pd_cnt + 16'h0001;
          if (pd_cnt == 16'(DP_ENTRY_CYC - 1)) pd_state <= P_DOWN;
        end
        P_DOWN: begin
          if (rel_seen) begin
            pd_state <= P_WAKING;
            pd_cnt   <= 16'h0000;
          end
        end
        P_WAKING: begin
          pd_cnt <= pd_cnt + 16'h0001;
          if (pd_cnt == 16'(RES_WAKE_CYC - 1)) pd_state <= P_NORMAL;
        end
      endcase
    end
  end

  assign powered_down = (pd_state != P_NORMAL);

  ////////////////////////////////////////////////////////////////////////////
  // ID output shifter
  typedef enum logic [1:0] {M_NONE, M_DEV, M_MFR, M_DUAL} fsc_id_t;
  fsc_id_t id_mode;
  logic [15:0] id_sh;
  logic        out_en;

  wire rel_ok  = (opcode == OP_RELEASE) && !busy;
  wire mfr_ok  = !powered_down && (opcode == OP_MFR_ID);
  wire dual_ok = !powered_down && (opcode == OP_MFR_ID_2);
  wire id_go   = sck_fall && !out_en &&
                 ((rel_ok && clk_cnt == DUMMY_BITS) || (mfr_ok && clk_cnt == ADDR_BITS)
                 || (dual_ok && clk_cnt == ADDR2_CLKS));
  // Output moves on falling serial edges so the host samples mid-bit on rises
  wire [15:0] pair = {MFR_ID_VAL, DEV_ID_VAL};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      id_mode <= M_NONE;
      id_sh   <= 16'h0000;
      out_en  <= 1'b0;
    end else if (cs_s) begin
      id_mode <= M_NONE;
      out_en  <= 1'b0;
    end else if (id_go) begin
      out_en <= 1'b1;
      if (rel_ok) begin
        id_mode <= M_DEV;
        id_sh   <= {DEV_ID_VAL, DEV_ID_VAL};
      end else if (mfr_ok) begin
        id_mode <= M_MFR;
        id_sh   <= pair;
      end else begin
        id_mode <= M_DUAL;
        id_sh   <= pair;
      end
    end else if (sck_fall && out_en) begin
      // Rotate so the stream repeats until select rises
      if (id_mode == M_DUAL) id_sh <= {id_sh[13:0], id_sh[15:14]};
      else                   id_sh <= {id_sh[14:0], id_sh[15]};
    end
  end

  // Dual mode puts the higher bit on io1; single mode drives io1 only
  assign io1_oe  = out_en;
  assign io0_oe  = out_en && (id_mode == M_DUAL);
  assign io1_out = id_sh[15];
  assign io0_out = (id_mode == M_DUAL) ? id_sh[14] : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Each property watches one rule where the logic acts on it
  AST_SUS_SETS: assert property (@(posedge clk) disable iff (!rst_n)
    susp_ok |=> suspend_status_bit && busy) else $error("suspend flag not set");
  AST_SUS_IGN: assert property (@(posedge clk) disable iff (!rst_n)
    (exact8 && opcode == OP_SUSPEND && suspend_status_bit)
    |=> suspend_status_bit && $stable(sus_kind))
    else $error("suspend taken while suspended");
  AST_CHIP_IGN: assert property (@(posedge clk) disable iff (!rst_n)
    (sus_state == S_RUN && array_op == FSC_OP_CHIP) |=> sus_state == S_RUN)
    else $error("chip erase suspended");
  AST_ERASE_REF: assert property (@(posedge clk) disable iff (!rst_n)
    (sus_kind == FSC_OP_ERASE && is_erase) |-> !op_allow) else $error("erase passed");
  AST_PROG_REF: assert property (@(posedge clk) disable iff (!rst_n)
    (sus_kind == FSC_OP_PROG && opcode == OP_WRSR) |-> !op_allow) else $error("wrsr passed");
  AST_RES_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
    res_ok |=> (!suspend_status_bit && busy) [*8]) else $error("resume busy wrong");
  AST_RES_DROP: assert property (@(posedge clk) disable iff (!rst_n)
    res_ok |=> !array_pause) else $error("engine still paused after resume");
  AST_RES_IGN: assert property (@(posedge clk) disable iff (!rst_n)
    (exact8 && opcode == OP_RESUME && (!suspend_status_bit || busy))
    |=> sus_state != S_RESUMING || $past(sus_state) == S_RESUMING)
    else $error("resume taken while not suspended or busy");
  AST_PD_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
    (pd_state == P_DOWN) |-> !op_allow && !(id_go && !rel_ok)) else $error("op in power-down");
  AST_PD_ENTER: assert property (@(posedge clk) disable iff (!rst_n)
    (pd_state == P_NORMAL && exact8 && opcode == OP_PWRDOWN && !busy) |=> powered_down)
    else $error("power-down not entered");
  AST_PD_LATE: assert property (@(posedge clk) disable iff (!rst_n)
    (pd_state == P_NORMAL && cs_rise && clk_cnt != OP_BITS) |=> !powered_down)
    else $error("power-down without an exact opcode frame");
  AST_PD_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
    (pd_state == P_DOWN && cs_rise && opcode != OP_RELEASE) |=> pd_state == P_DOWN)
    else $error("power-down left without release");
  AST_REL_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
    (busy && opcode == OP_RELEASE) |-> !id_go) else $error("release while busy");
  AST_OE_DROP: assert property (@(posedge clk) disable iff (!rst_n)
    cs_s |=> !io1_oe && !io0_oe) else $error("output still driven after select rise");
  COV_REL_ID:  cover property (@(posedge clk) disable iff (!rst_n) rel_seen && out_en);
  COV_SUSPEND: cover property (@(posedge clk) disable iff (!rst_n) susp_ok);
  COV_RESUME:  cover property (@(posedge clk) disable iff (!rst_n) res_ok);
  COV_PD:      cover property (@(posedge clk) disable iff (!rst_n) pd_state == P_DOWN);
  COV_DUAL:    cover property (@(posedge clk) disable iff (!rst_n) id_go && dual_ok);

endmodule
`default_nettype wire

// ### src/fsc_pkg.sv
// Purpose: Shared constants for the flash suspend / power-down / ID command block
// Assumes: Serial link sampled by a 100 MHz system clock
// Notes:   Opcodes used by the block, ID values and timing counts live here only
package fsc_pkg;

  // Opcodes
  localparam logic [7:0] OP_SUSPEND   = 8'h75;
  localparam logic [7:0] OP_RESUME    = 8'h7a;
  localparam logic [7:0] OP_PWRDOWN   = 8'hb9;
  localparam logic [7:0] OP_RELEASE   = 8'hab;
  localparam logic [7:0] OP_MFR_ID    = 8'h90;
  localparam logic [7:0] OP_MFR_ID_2  = 8'h92;
  localparam logic [7:0] OP_WRSR      = 8'h01;
  localparam logic [7:0] OP_SE        = 8'h20;
  localparam logic [7:0] OP_BE32      = 8'h52;
  localparam logic [7:0] OP_BE64      = 8'hd8;
  localparam logic [7:0] OP_CE_A      = 8'hc7;
  localparam logic [7:0] OP_CE_B      = 8'h60;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;
  localparam logic [7:0] OP_PP        = 8'h02;
  localparam logic [7:0] OP_QPP       = 8'h32;
  localparam logic [7:0] OP_SEC_PROG  = 8'h42;

  // Identification values: arbitrary neutral codes
  localparam logic [7:0] MFR_ID_VAL   = 8'h5a;
  localparam logic [7:0] DEV_ID_VAL   = 8'h17;

  // Frame bit counts
  localparam logic [5:0] OP_BITS      = 6'd8;
  localparam logic [5:0] DUMMY_BITS   = 6'd32;   // Opcode plus three dummy bytes
  localparam logic [5:0] ADDR_BITS    = 6'd32;   // Opcode plus 24-bit address
  localparam logic [5:0] ADDR2_CLKS   = 6'd24;   // Opcode 8 clocks plus 12 addr + 4 mode

  // Timing
  localparam int CLK_NS          = 10;
  localparam int RESUME_BUSY_NS  = 200;
  localparam int RESUME_CYC      = RESUME_BUSY_NS / CLK_NS; // Longest time, rounded down
  localparam int SUS_LAT_NS      = 20000;
  localparam int SUS_LAT_CYC     = SUS_LAT_NS / CLK_NS;
  localparam int DP_ENTRY_NS     = 3000;
  localparam int DP_ENTRY_CYC    = DP_ENTRY_NS / CLK_NS;
  localparam int RES_WAKE_NS     = 3000;
  localparam int RES_WAKE_CYC    = (RES_WAKE_NS + CLK_NS - 1) / CLK_NS;

  // Kind of self-timed operation
  typedef enum logic [1:0] {
    FSC_OP_NONE,
    FSC_OP_ERASE,
    FSC_OP_PROG,
    FSC_OP_CHIP
  } fsc_op_t;

endpackage

// ### src/fsc_sync.sv
// Purpose: Two-flop synchroniser for pin levels
// Assumes: Input is asynchronous to clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module fsc_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Data
  input  wire logic d,
  output logic      q
);
  logic meta;

  // Reset value is idle-high so chip select starts deselected
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b1;
      q    <= 1'b1;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// ### bench/fsc_host.sv
// Purpose: SPI host model for the command block's serial pins
// Assumes: Mode 0 framing, 125 ns serial clock that stands still between frames
// Notes:   Released data lines show the inverse of the last bit driven
`timescale 1ns/10ps
`default_nettype none
module fsc_host (
  // Resolved lines and status from the device
  input  wire logic io0,
  input  wire logic io1,
  input  wire logic io1_oe,
  input  wire logic op_allow,
  // Host pins
  output logic      cs_n,
  output logic      sck,
  output logic      h_io0,
  output logic      h_io1
);
  ////////////////////////////////////////
  // Idle pins at time zero
  initial begin
    cs_n  = 1'b1;
    sck   = 1'b0;
    h_io0 = 1'b0;
    h_io1 = 1'b1;
  end
  // One frame: opcode, n_in address or dummy clocks, n_out read clocks
  task automatic xfer(input logic [7:0] op, input int n_in, input int n_out,
                      input bit dual, output logic [31:0] rx, output logic drv,
                      output logic allow);
    logic [31:0] m;
    m = 32'h0000_00f0; // Zero address, mode bits upper nibble ones
    rx = '0;
    drv = 1'b0;
    // Offset keeps serial edges clear of the system clock edges
    #3 cs_n = 1'b0;
    for (int i = 0; i < 8 + n_in + n_out; i++) begin
      if (i < 8) h_io0 = op[7 - i];
      else if (i < 8 + n_in) {h_io1, h_io0} = dual ? m[31:30] : 2'b00;
      else if (i == 8 + n_in) {h_io1, h_io0} = ~{h_io1, h_io0};
      #62.5 sck = 1'b1;
      if (i >= 8 + n_in) begin
        rx = dual ? {rx[29:0], io1, io0} : {rx[30:0], io1};
        drv = drv | io1_oe;
      end
      #62.5 sck = 1'b0;
      if (dual && i >= 8) m = {m[29:0], 2'b00};
    end
    #100 allow = op_allow;
    cs_n = 1'b1; // Select rises 100 ns after the last clock falls
    {h_io1, h_io0} = ~{h_io1, h_io0};
    #80;
  endtask
endmodule
`default_nettype wire

// ### bench/tb_fsc_cmd.sv
// Purpose: Self-checking bench for the suspend, power-down and ID command block
// Assumes: Host model drives the serial pins, the bench plays the array engine
// Notes:   Random ID lengths and opcodes come from one fixed seed
`timescale 1ns/10ps
`default_nettype none
module tb_fsc_cmd;
  import fsc_pkg::*;
  // Bench signals
  logic        clk, rst_n, cs_n, sck, h_io0, h_io1, io0_out, io0_oe, io1_out, io1_oe;
  logic        array_done, array_pause, op_allow, busy, suspend_status_bit, powered_down;
  fsc_op_t     array_op;
  logic [31:0] rx;
  logic        drv, al;
  logic [7:0]  op;
  int          n_mismatch = 0;
  int          checked = 0;
  int          nb;
  wire         io0, io1;
  fsc_op_t     kinds [3] = '{FSC_OP_ERASE, FSC_OP_PROG, FSC_OP_CHIP};
  logic [7:0]  ops [11] = '{OP_WRSR, OP_SE, OP_BE32, OP_BE64, OP_CE_A, OP_CE_B,
                            OP_SEC_ERASE, OP_PP, OP_QPP, OP_SEC_PROG, 8'h03};
  ////////////////////////////////////////
  // Each shared line carries whoever has it enabled
  assign io0 = io0_oe ? io0_out : h_io0;
  assign io1 = io1_oe ? io1_out : h_io1;
  // System clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  fsc_cmd fsc_cmd_inst (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .io0_in(io0),
    .io1_in(io1), .io0_out(io0_out), .io0_oe(io0_oe), .io1_out(io1_out), .io1_oe(io1_oe),
    .array_op(array_op), .array_done(array_done), .array_pause(array_pause),
    .op_allow(op_allow), .busy(busy), .suspend_status_bit(suspend_status_bit),
    .powered_down(powered_down));
  fsc_host fsc_host_inst (.io0(io0), .io1(io1), .io1_oe(io1_oe), .op_allow(op_allow),
    .cs_n(cs_n), .sck(sck), .h_io0(h_io0), .h_io1(h_io1));
  // Expected ID stream: maker and device bytes alternate, or device byte alone
  function automatic logic [31:0] id_exp(input bit mfr, input int nbits);
    logic [31:0] r;
    logic [7:0]  b;
    r = '0;
    for (int i = 0; i < nbits; i++) begin
      b = (mfr && (i / 8) % 2 == 0) ? MFR_ID_VAL : DEV_ID_VAL;
      r = {r[30:0], b[7 - i % 8]};
    end
    return r;
  endfunction
  // Whether an opcode may reach the engine while an op of kind k is suspended
  function automatic logic allow_exp(input fsc_op_t k, input logic [7:0] c);
    logic er, pg;
    er = c inside {OP_SE, OP_BE32, OP_BE64, OP_CE_A, OP_CE_B, OP_SEC_ERASE};
    pg = c inside {OP_PP, OP_QPP, OP_SEC_PROG};
    return !(c == OP_WRSR || (k == FSC_OP_ERASE ? er : pg));
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Frame through the host, then realign to the falling edge
  task automatic frame(input logic [7:0] c, input int n_in, input int n_out, input bit dual);
    fsc_host_inst.xfer(c, n_in, n_out, dual, rx, drv, al);
    @(negedge clk);
  endtask
  // Bounded wait for busy, then compare
  task automatic wait_busy(input logic v, input int n);
    for (int k = 0; k < n && busy !== v; k++) @(negedge clk);
    chk("busy", {31'h0, v}, {31'h0, busy});
  endtask
  // Watchdog well beyond the expected run of about 210 us
  initial begin
    #1000000;
    n_mismatch++;
    close_out();
  end
  // Main sequence
  initial begin
    void'($urandom(73086));
    rst_n = 1'b0;
    array_op = FSC_OP_NONE;
    array_done = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    chk("powered_down", 0, powered_down);
    chk("flag", 0, suspend_status_bit);
    chk("busy", 0, busy);
    nb = 1 + $urandom % 4;
    frame(OP_RELEASE, 24, 8 * nb, 1'b0);
    chk("device id", id_exp(1'b0, 8 * nb), rx);
    repeat (RES_WAKE_CYC) @(negedge clk);
    nb = 2 + $urandom % 3;
    frame(OP_MFR_ID, 24, 8 * nb, 1'b0);
    chk("maker id", id_exp(1'b1, 8 * nb), rx);
    frame(OP_MFR_ID_2, 16, 16, 1'b1);
    chk("dual id", id_exp(1'b1, 32), rx);
    // Try to suspend each kind of running op; for erase and program, probe refusals, resume
    for (int k = 0; k < 3; k++) begin
      array_op = kinds[k];
      wait_busy(1'b1, 5);
      frame(OP_SUSPEND, 0, 0, 1'b0);
      chk("flag", kinds[k] != FSC_OP_CHIP, suspend_status_bit);
      if (kinds[k] != FSC_OP_CHIP) begin
        wait_busy(1'b0, SUS_LAT_CYC + 20);
        chk("pause", 1, array_pause);
        frame(OP_SUSPEND, 0, 0, 1'b0);
        chk("flag", 1, suspend_status_bit);
        foreach (ops[j]) begin
          frame(ops[j], 0, 0, 1'b0);
          chk("allow", allow_exp(kinds[k], ops[j]), al);
        end
        frame(OP_RESUME, 0, 0, 1'b0);
        chk("flag", 0, suspend_status_bit);
        chk("busy", 1, busy);
        repeat (SUS_LAT_CYC) @(negedge clk);
      end
      else chk("busy", 1, busy);
      array_op = FSC_OP_NONE;
      array_done = 1'b1;
      wait_busy(1'b0, 20);
      array_done = 1'b0;
    end
    frame(OP_RESUME, 0, 0, 1'b0);
    chk("busy", 0, busy);
    frame(OP_SUSPEND, 0, 0, 1'b0);
    chk("flag", 0, suspend_status_bit);
    // Power loss while suspended
    array_op = FSC_OP_ERASE;
    frame(OP_SUSPEND, 0, 0, 1'b0);
    wait_busy(1'b0, SUS_LAT_CYC + 20);
    rst_n = 1'b0;
    array_op = FSC_OP_NONE;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk("flag", 0, suspend_status_bit);
    repeat (5) @(negedge clk);
    frame(OP_RESUME, 0, 0, 1'b0);
    chk("busy", 0, busy);
    chk("flag", 0, suspend_status_bit);
    // Power-down: late select rise, proper entry, ignored opcodes, release
    frame(OP_PWRDOWN, 1, 0, 1'b0);
    repeat (DP_ENTRY_CYC + 20) @(negedge clk);
    chk("powered_down", 0, powered_down);
    frame(OP_PWRDOWN, 0, 0, 1'b0);
    repeat (DP_ENTRY_CYC + 20) @(negedge clk);
    chk("powered_down", 1, powered_down);
    for (int k = 0; k < 3; k++) begin
      op = 8'($urandom);
      if (op == OP_RELEASE) op = OP_MFR_ID;
      frame(op, 24, 16, 1'b0);
      chk("id drive", 0, drv);
    end
    frame(OP_RELEASE, 0, 0, 1'b0);
    repeat (RES_WAKE_CYC + 20) @(negedge clk);
    chk("powered_down", 0, powered_down);
    // Release with ID straight out of power-down, then the same wake time
    frame(OP_PWRDOWN, 0, 0, 1'b0);
    repeat (DP_ENTRY_CYC + 20) @(negedge clk);
    frame(OP_RELEASE, 24, 8, 1'b0);
    chk("wake id", id_exp(1'b0, 8), rx);
    chk("powered_down", 1, powered_down);
    repeat (RES_WAKE_CYC + 20) @(negedge clk);
    chk("powered_down", 0, powered_down);
    // Release/ID while busy has no effect
    array_op = FSC_OP_ERASE;
    wait_busy(1'b1, 5);
    frame(OP_RELEASE, 24, 16, 1'b0);
    chk("id drive", 0, drv);
    chk("busy", 1, busy);
    close_out();
  end
endmodule
`default_nettype wire
